// file: hdl/ppps_top.sv
// Parallel port pins with peripheral sharing for ports A to C and pin G0
`timescale 1ns/10ps
module ppps_top (
  // Clock and reset
  input  wire logic                           sys_clk_i,
  input  wire logic                           reset_n_i,
  // CPU register access
  input  wire logic                           cpu_wr_i,
  input  wire logic                           cpu_rd_i,
  input  wire logic [ppps_pkg::PORT_SEL_W-1:0] cpu_port_i,
  input  wire logic [ppps_pkg::REG_SEL_W-1:0]  cpu_reg_i,
  input  wire logic [ppps_pkg::PORT_W-1:0]     cpu_wdata_i,
  output logic      [ppps_pkg::PORT_W-1:0]     cpu_rdata_o,
  // System options background enable
  input  wire logic                           sysopt_wr_i,
  input  wire logic                           sysopt_bkgd_pe_i,
  output logic                                background_pin_enable_o,
  // Keyboard interrupt and analog converter
  input  wire logic [ppps_pkg::PORT_W-1:0]     keyboard_interrupt_input_i,
  input  wire logic                           adc_enable_i,
  input  wire logic [ppps_pkg::PORT_W-1:0]     analog_converter_input_i,
  // Second async serial
  input  wire logic                           second_async_serial_en_i,
  input  wire logic                           serial_transmit_line_i,
  // Two-wire serial
  input  wire logic                           two_wire_serial_en_i,
  input  wire logic                           two_wire_data_line_out_i,
  input  wire logic                           two_wire_data_line_oe_i,
  input  wire logic                           two_wire_clock_line_out_i,
  input  wire logic                           two_wire_clock_line_oe_i,
  // Background pin drive
  input  wire logic                           bkgd_out_i,
  input  wire logic                           bkgd_oe_i,
  // Synchronised pin levels for peripheral inputs
  output logic      [ppps_pkg::NUM_PINS-1:0]   pin_level_o,
  // Package pins
  input  wire logic [ppps_pkg::NUM_PINS-1:0]   pin_in_i,
  output logic      [ppps_pkg::NUM_PINS-1:0]   pin_out_o,
  output logic      [ppps_pkg::NUM_PINS-1:0]   pin_oe_o,
  output logic      [ppps_pkg::NUM_PINS-1:0]   pin_pullup_o,
  output logic      [ppps_pkg::NUM_PINS-1:0]   pin_slew_o
);
  import ppps_pkg::*;

  localparam int IDX_C_TX  = pin_index(PORT_C, BIT_TRANSMIT);
  localparam int IDX_C_RX  = pin_index(PORT_C, BIT_RECEIVE);
  localparam int IDX_C_SDA = pin_index(PORT_C, BIT_TW_DATA);
  localparam int IDX_C_SCL = pin_index(PORT_C, BIT_TW_CLOCK);
  localparam int IDX_G_BKG = pin_index(PORT_G, BIT_BKGD);
  localparam int IDX_A     = pin_index(PORT_A, 0);
  localparam int IDX_B     = pin_index(PORT_B, 0);

  // Port registers, one byte per port
  logic [PORT_W-1:0]   latch_r  [NUM_PORTS];
  logic [PORT_W-1:0]   dir_r    [NUM_PORTS];
  logic [PORT_W-1:0]   pullup_r [NUM_PORTS];
  logic [PORT_W-1:0]   slew_r   [NUM_PORTS];
  logic                bkgd_pe_r;
  logic [NUM_PINS-1:0] pin_meta_r;
  logic [NUM_PINS-1:0] pin_sync_r;
  logic [PORT_W-1:0]   rdata_r;

  wire logic [NUM_PINS-1:0] dir_flat;
  wire logic [NUM_PINS-1:0] pullup_flat;
  wire logic [NUM_PINS-1:0] slew_flat;
  wire logic [NUM_PINS-1:0] latch_flat;
  wire logic [NUM_PINS-1:0] owned;
  wire logic [NUM_PINS-1:0] own_oe;
  wire logic [NUM_PINS-1:0] own_out;
  wire logic [NUM_PINS-1:0] oe_nxt;
  wire logic [NUM_PINS-1:0] out_nxt;
  wire logic [NUM_PINS-1:0] pullup_nxt;
  wire logic [NUM_PINS-1:0] slew_nxt;
  wire logic [NUM_PINS-1:0] read_bits;
  wire logic [PORT_W-1:0]   adc_owned;
  wire logic [PORT_W-1:0]   rdata_nxt;
  wire logic                port_ok;
  wire logic                wr_data;
  wire logic                wr_dir;
  wire logic                wr_pullup;
  wire logic                wr_slew;

  // Access decode; ports past G are ignored and read zero
  assign port_ok   = int'(cpu_port_i) < NUM_PORTS;
  assign wr_data   = cpu_wr_i & port_ok & (cpu_reg_i == REG_DATA);
  assign wr_dir    = cpu_wr_i & port_ok & (cpu_reg_i == REG_DIR);
  assign wr_pullup = cpu_wr_i & port_ok & (cpu_reg_i == REG_PULLUP);
  assign wr_slew   = cpu_wr_i & port_ok & (cpu_reg_i == REG_SLEW);

  // Peripheral ownership of pins
  assign adc_owned = adc_enable_i ? analog_converter_input_i
                                  : {PORT_W{1'b0}};

  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : g_own
      if (g >= IDX_A && g < IDX_A + PORT_W) begin : g_keys
        assign owned[g]   = keyboard_interrupt_input_i[g-IDX_A];
        assign own_oe[g]  = 1'b0;
        assign own_out[g] = 1'b0;
      end else if (g >= IDX_B && g < IDX_B + PORT_W) begin : g_adc
        assign owned[g]   = adc_owned[g-IDX_B];
        assign own_oe[g]  = 1'b0;
        assign own_out[g] = 1'b0;
      end else if (g == IDX_C_TX) begin : g_tx
        assign owned[g]   = second_async_serial_en_i;
        assign own_oe[g]  = 1'b1;
        assign own_out[g] = serial_transmit_line_i;
      end else if (g == IDX_C_RX) begin : g_rx
        assign owned[g]   = second_async_serial_en_i;
        assign own_oe[g]  = 1'b0;
        assign own_out[g] = 1'b0;
      end else if (g == IDX_C_SDA) begin : g_sda
        assign owned[g]   = two_wire_serial_en_i;
        assign own_oe[g]  = two_wire_data_line_oe_i;
        assign own_out[g] = two_wire_data_line_out_i;
      end else if (g == IDX_C_SCL) begin : g_scl
        assign owned[g]   = two_wire_serial_en_i;
        assign own_oe[g]  = two_wire_clock_line_oe_i;
        assign own_out[g] = two_wire_clock_line_out_i;
      end else if (g == IDX_G_BKG) begin : g_bkgd
        assign owned[g]   = bkgd_pe_r;
        assign own_oe[g]  = bkgd_oe_i;
        assign own_out[g] = bkgd_out_i;
      end else begin : g_gpio
        assign owned[g]   = 1'b0;
        assign own_oe[g]  = 1'b0;
        assign own_out[g] = 1'b0;
      end

      assign dir_flat[g]    = dir_r[g/PORT_W][g%PORT_W];
      assign pullup_flat[g] = pullup_r[g/PORT_W][g%PORT_W];
      assign slew_flat[g]   = slew_r[g/PORT_W][g%PORT_W];
      assign latch_flat[g]  = latch_r[g/PORT_W][g%PORT_W];

      ppps_pin_cell #(
        .OUTPUT_ONLY (g == IDX_G_BKG)
      ) u_cell (
        .dir_i         (dir_flat[g]),
        .pullup_en_i   (pullup_flat[g]),
        .slew_en_i     (slew_flat[g]),
        .latch_i       (latch_flat[g]),
        .owned_i       (owned[g]),
        .own_oe_i      (own_oe[g]),
        .own_out_i     (own_out[g]),
        .pin_level_i   (pin_sync_r[g]),
        .pin_out_now_i (pin_out_o[g]),
        .oe_o          (oe_nxt[g]),
        .out_o         (out_nxt[g]),
        .pullup_o      (pullup_nxt[g]),
        .slew_o        (slew_nxt[g]),
        .read_o        (read_bits[g])
      );
    end
  endgenerate

  // Background function keeps its pin pulled up while it owns it
  logic [NUM_PINS-1:0] pullup_pin_nxt;
  always_comb begin
    pullup_pin_nxt = pullup_nxt;
    pullup_pin_nxt[IDX_G_BKG] = pullup_nxt[IDX_G_BKG] | bkgd_pe_r;
  end

  assign rdata_nxt = !port_ok ? {PORT_W{1'b0}}
                   : (cpu_reg_i == REG_DATA)   ?
                       read_bits[int'(cpu_port_i)*PORT_W +: PORT_W]
                   : (cpu_reg_i == REG_DIR)    ? dir_r[cpu_port_i]
                   : (cpu_reg_i == REG_PULLUP) ? pullup_r[cpu_port_i]
                   : slew_r[cpu_port_i];

  // Port register writes
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        latch_r[p]  <= RST_LATCH;
        dir_r[p]    <= RST_DIR;
        pullup_r[p] <= RST_PULLUP;
        slew_r[p]   <= RST_SLEW;
      end
    end else begin
      if (wr_data) begin
        latch_r[cpu_port_i] <= cpu_wdata_i;
      end
      if (wr_dir) begin
        dir_r[cpu_port_i] <= cpu_wdata_i;
      end
      if (wr_pullup) begin
        pullup_r[cpu_port_i] <= cpu_wdata_i;
      end
      if (wr_slew) begin
        slew_r[cpu_port_i] <= cpu_wdata_i;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bkgd_pe_r <= RST_BKGD_PE;
    end else if (sysopt_wr_i) begin
      bkgd_pe_r <= sysopt_bkgd_pe_i;
    end
  end

  // Pin levels pass two flops before any use
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end else begin
      pin_meta_r <= pin_in_i;
      pin_sync_r <= pin_meta_r;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_r <= '0;
    end else if (cpu_rd_i) begin
      rdata_r <= rdata_nxt;
    end
  end

  // Registered pin drive
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_out_o    <= '0;
      pin_oe_o     <= '0;
      pin_pullup_o <= '0;
      pin_slew_o   <= '0;
    end else begin
      pin_out_o    <= out_nxt;
      pin_oe_o     <= oe_nxt;
      pin_pullup_o <= pullup_pin_nxt;
      pin_slew_o   <= slew_nxt;
    end
  end

  assign cpu_rdata_o             = rdata_r;
  assign background_pin_enable_o = bkgd_pe_r;
  assign pin_level_o             = pin_sync_r;
endmodule

// file: hdl/ppps_pin_cell.sv
// Package of port constants and the per-pin direction and drive cell
// Function
// - The block holds 56 pins as seven 8-bit ports, one pin output-only.
// - Each pin has data, direction, pullup enable and slew bits.
// - A pin that no peripheral controls is run by its port registers.
// - Reset clears every direction and pullup bit, leaving floating inputs except G0, which background pulls up.
// - Background owns its pin after reset until software clears its enable.
// - A port A pin enabled for keyboard interrupts is forced to be an input.
// - A port B pin picked by the enabled converter is forced to be an input.
// - An enabled serial module sets the direction of the C pins it uses.
// - The async serial module drives transmit on C0 and reads receive on C1.
// - The two-wire module uses C2 for its data line and C3 for its clock.
// - Port G bit 0 is an output only, with no general input path.
// - A data read gives the latch when the direction bit is set, else the pin level, or on G0 the driven level.
// - A data write always loads the latch; it drives only unowned outputs.
// - The direction bit picks the read source even for an owned pin.
// - The pullup acts only while the direction bit says input, except on G0, which background pulls up while it owns the pin.
`timescale 1ns/10ps
package ppps_pkg;
  localparam int NUM_PORTS  = 7;
  localparam int PORT_W     = 8;
  localparam int NUM_PINS   = NUM_PORTS * PORT_W;
  localparam int PORT_SEL_W = 3;
  localparam int REG_SEL_W  = 2;

  localparam logic [PORT_SEL_W-1:0] PORT_A = 3'h0;
  localparam logic [PORT_SEL_W-1:0] PORT_B = 3'h1;
  localparam logic [PORT_SEL_W-1:0] PORT_C = 3'h2;
  localparam logic [PORT_SEL_W-1:0] PORT_G = 3'h6;

  localparam logic [REG_SEL_W-1:0] REG_DATA   = 2'h0;
  localparam logic [REG_SEL_W-1:0] REG_DIR    = 2'h1;
  localparam logic [REG_SEL_W-1:0] REG_PULLUP = 2'h2;
  localparam logic [REG_SEL_W-1:0] REG_SLEW   = 2'h3;

  localparam int BIT_TRANSMIT = 0;
  localparam int BIT_RECEIVE  = 1;
  localparam int BIT_TW_DATA  = 2;
  localparam int BIT_TW_CLOCK = 3;
  localparam int BIT_BKGD     = 0;

  localparam logic [PORT_W-1:0] RST_LATCH  = 8'h00;
  localparam logic [PORT_W-1:0] RST_DIR    = 8'h00;
  localparam logic [PORT_W-1:0] RST_PULLUP = 8'h00;
  localparam logic [PORT_W-1:0] RST_SLEW   = 8'h00;
  localparam logic              RST_BKGD_PE = 1'b1;

  function automatic int pin_index(input logic [PORT_SEL_W-1:0] port,
                                   input int bit_pos);
    return int'(port) * PORT_W + bit_pos;
  endfunction
endpackage

module ppps_pin_cell #(
  parameter bit OUTPUT_ONLY = 1'b0
) (
  // Port register bits
  input  wire logic dir_i,
  input  wire logic pullup_en_i,
  input  wire logic slew_en_i,
  input  wire logic latch_i,
  // Peripheral request
  input  wire logic owned_i,
  input  wire logic own_oe_i,
  input  wire logic own_out_i,
  // Pin side
  input  wire logic pin_level_i,
  input  wire logic pin_out_now_i,
  output logic      oe_o,
  output logic      out_o,
  output logic      pullup_o,
  output logic      slew_o,
  output logic      read_o
);
  wire logic gpio_oe;

  // Unowned output-only pin always drives its latch
  assign gpio_oe  = OUTPUT_ONLY ? 1'b1 : dir_i;
  assign oe_o     = owned_i ? own_oe_i : gpio_oe;
  assign out_o    = owned_i ? own_out_i : latch_i;
  assign pullup_o = pullup_en_i & ~dir_i;
  assign slew_o   = slew_en_i & oe_o;
  // Output-only pin reads back the driven level, or the latch when dir_i is set, never an input path
  assign read_o   = dir_i ? latch_i
                  : (OUTPUT_ONLY ? pin_out_now_i : pin_level_i);
endmodule

// file: dv/ppps_assertions.sv
// Port-level checks for the pin sharing block
`timescale 1ns/10ps
module ppps_assertions (
  // Clock, reset and register bus
  input wire logic        sys_clk_i,
  input wire logic        reset_n_i,
  input wire logic        cpu_rd_i,
  input wire logic [2:0]  cpu_port_i,
  input wire logic [7:0]  cpu_rdata_o,
  // Sharing controls
  input wire logic        sysopt_wr_i,
  input wire logic        sysopt_bkgd_pe_i,
  input wire logic        background_pin_enable_o,
  input wire logic [7:0]  keyboard_interrupt_input_i,
  input wire logic        adc_enable_i,
  input wire logic [7:0]  analog_converter_input_i,
  input wire logic        second_async_serial_en_i,
  input wire logic        serial_transmit_line_i,
  input wire logic        two_wire_serial_en_i,
  input wire logic        two_wire_data_line_out_i,
  input wire logic        two_wire_data_line_oe_i,
  input wire logic        bkgd_oe_i,
  // Pads
  input wire logic [55:0] pin_out_o,
  input wire logic [55:0] pin_oe_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  a_keys_forced_in: assert property (
    |keyboard_interrupt_input_i |=>
    (pin_oe_o[7:0] & $past(keyboard_interrupt_input_i)) == 8'h00)
    else $error("keyboard pin driven");
  a_adc_forced_in: assert property (
    adc_enable_i |=>
    (pin_oe_o[15:8] & $past(analog_converter_input_i)) == 8'h00)
    else $error("analog pin driven");
  a_serial_pins: assert property (
    second_async_serial_en_i |=> pin_oe_o[16] && !pin_oe_o[17] &&
    pin_out_o[16] == $past(serial_transmit_line_i))
    else $error("serial pins wrong");
  a_tw_data_pin: assert property (
    two_wire_serial_en_i |=> pin_oe_o[18] == $past(two_wire_data_line_oe_i)
    && (!pin_oe_o[18] || pin_out_o[18] == $past(two_wire_data_line_out_i)))
    else $error("two-wire data pin wrong");
  a_bkgd_owns_pin: assert property (
    background_pin_enable_o |=> pin_oe_o[48] == $past(bkgd_oe_i))
    else $error("background pin drive wrong");
  a_sysopt_load: assert property (
    sysopt_wr_i |=> background_pin_enable_o == $past(sysopt_bkgd_pe_i))
    else $error("background enable not loaded");
  a_unmapped_read: assert property (
    cpu_rd_i && cpu_port_i == 3'h7 |=> cpu_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (
    !cpu_rd_i |=> $stable(cpu_rdata_o))
    else $error("read data moved without read");
endmodule

bind ppps_top ppps_assertions u_chk (.sys_clk_i, .reset_n_i, .cpu_rd_i,
  .cpu_port_i, .cpu_rdata_o, .sysopt_wr_i, .sysopt_bkgd_pe_i,
  .background_pin_enable_o, .keyboard_interrupt_input_i, .adc_enable_i,
  .analog_converter_input_i, .second_async_serial_en_i,
  .serial_transmit_line_i, .two_wire_serial_en_i, .two_wire_data_line_out_i,
  .two_wire_data_line_oe_i, .bkgd_oe_i, .pin_out_o, .pin_oe_o);

// file: dv/ppps_board.sv
// Board model giving the pad levels seen by the block
`timescale 1ns/10ps
module ppps_board (
  // Pad controls from the block
  input  wire logic        clk_i,
  input  wire logic [55:0] out_i,
  input  wire logic [55:0] oe_i,
  input  wire logic [55:0] pullup_i,
  // External drivers on the board
  input  wire logic [55:0] ext_en_i,
  input  wire logic [55:0] ext_val_i,
  output logic      [55:0] pad_o
);
  logic [55:0] float_r = '0;
  // Undriven unpulled pads wander so a stale level is never trusted
  always @(posedge clk_i) float_r <= ~pad_o;
  assign pad_o = (oe_i & out_i) | (~oe_i & ((ext_en_i & ext_val_i) |
                 (~ext_en_i & (pullup_i | float_r))));
endmodule

// file: dv/ppps_top_test.sv
// Self-checking bench for the pin sharing block
`timescale 1ns/10ps
module ppps_top_test;
  import ppps_pkg::*;
  typedef struct {logic [2:0] p; logic [1:0] r; logic [7:0] d, e;} ppps_row_t;
  logic        sys_clk_i = 1'b0;
  logic        reset_n_i, cpu_wr_i, cpu_rd_i, sysopt_wr_i, sysopt_bkgd_pe_i;
  logic        background_pin_enable_o, adc_enable_i, bkgd_out_i, bkgd_oe_i;
  logic        second_async_serial_en_i, serial_transmit_line_i;
  logic        two_wire_serial_en_i, two_wire_data_line_out_i;
  logic        two_wire_data_line_oe_i, two_wire_clock_line_out_i;
  logic        two_wire_clock_line_oe_i;
  logic [2:0]  cpu_port_i;
  logic [1:0]  cpu_reg_i;
  logic [7:0]  cpu_wdata_i, cpu_rdata_o;
  logic [7:0]  keyboard_interrupt_input_i, analog_converter_input_i;
  logic [55:0] pin_level_o, pin_in_i, pin_out_o, pin_oe_o;
  logic [55:0] pin_pullup_o, pin_slew_o;
  int          fail_count = 0;
  int          samples_checked = 0;
  ppps_row_t   rows [7] = '{
    '{3'h5, REG_DIR, 8'hF0, 8'hF0}, '{3'h5, REG_DATA, 8'h3C, 8'h35},
    '{3'h5, REG_PULLUP, 8'h0F, 8'h0F}, '{3'h5, REG_SLEW, 8'hAA, 8'hAA},
    '{3'h7, REG_DATA, 8'hFF, 8'h00}, '{3'h4, REG_DIR, 8'hFF, 8'hFF},
    '{3'h4, REG_DATA, 8'h5A, 8'h5A}};

  ppps_top i_dut (.sys_clk_i, .reset_n_i, .cpu_wr_i, .cpu_rd_i, .cpu_port_i,
    .cpu_reg_i, .cpu_wdata_i, .cpu_rdata_o, .sysopt_wr_i, .sysopt_bkgd_pe_i,
    .background_pin_enable_o, .keyboard_interrupt_input_i, .adc_enable_i,
    .analog_converter_input_i, .second_async_serial_en_i,
    .serial_transmit_line_i, .two_wire_serial_en_i, .two_wire_data_line_out_i,
    .two_wire_data_line_oe_i, .two_wire_clock_line_out_i,
    .two_wire_clock_line_oe_i, .bkgd_out_i, .bkgd_oe_i, .pin_level_o,
    .pin_in_i, .pin_out_o, .pin_oe_o, .pin_pullup_o, .pin_slew_o);
  ppps_board i_board (.clk_i(sys_clk_i), .out_i(pin_out_o), .oe_i(pin_oe_o),
    .pullup_i(pin_pullup_o), .ext_en_i({56{1'b1}}),
    .ext_val_i({7{8'h05}}), .pad_o(pin_in_i));

  always #25 sys_clk_i = ~sys_clk_i;

  task automatic chk(input logic [55:0] g, input logic [55:0] e);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  // One-cycle strobe, then time for pads and read data to settle
  task automatic acc(input logic w, input logic [2:0] p,
                     input logic [1:0] r, input logic [7:0] d);
    {cpu_wr_i, cpu_rd_i} = {w, !w};
    {cpu_port_i, cpu_reg_i, cpu_wdata_i} = {p, r, d};
    cyc(1);
    {cpu_wr_i, cpu_rd_i} = 2'b00;
    cyc(5);
  endtask
  task automatic print_verdict;
    $display("checked=%0d failed=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    {reset_n_i, cpu_wr_i, cpu_rd_i, sysopt_wr_i, sysopt_bkgd_pe_i} = '0;
    {adc_enable_i, bkgd_out_i, bkgd_oe_i, second_async_serial_en_i} = '0;
    {serial_transmit_line_i, two_wire_serial_en_i} = '0;
    {two_wire_data_line_out_i, two_wire_data_line_oe_i} = '0;
    {two_wire_clock_line_out_i, two_wire_clock_line_oe_i} = '0;
    {cpu_port_i, cpu_reg_i, cpu_wdata_i} = '0;
    {keyboard_interrupt_input_i, analog_converter_input_i} = '0;
    cyc(16);
    reset_n_i = 1'b1;
    cyc(2);
    chk(pin_oe_o, '0);
    chk(pin_pullup_o, 56'h01_0000_0000_0000);
    chk(background_pin_enable_o, 56'h1);
    acc(1'b0, PORT_A, REG_DIR, 8'h00);
    chk(cpu_rdata_o, 8'h00);
    foreach (rows[i]) begin
      acc(1'b1, rows[i].p, rows[i].r, rows[i].d);
      acc(1'b0, rows[i].p, rows[i].r, 8'h00);
      chk(cpu_rdata_o, rows[i].e);
    end
    chk(pin_oe_o[47:40], 8'hF0);
    chk(pin_pullup_o[47:40], 8'h0F);
    chk(pin_slew_o[47:40], 8'hA0);
    chk(pin_out_o[47:44], 4'h3);
    // Keyboard inputs win over an output direction
    acc(1'b1, PORT_A, REG_DIR, 8'hFF);
    acc(1'b1, PORT_A, REG_DATA, 8'h96);
    keyboard_interrupt_input_i = 8'h0F;
    cyc(3);
    chk(pin_oe_o[7:0], 8'hF0);
    acc(1'b0, PORT_A, REG_DATA, 8'h00);
    chk(cpu_rdata_o, 8'h96);
    acc(1'b1, PORT_B, REG_DIR, 8'hFF);
    analog_converter_input_i = 8'h3C;
    cyc(3);
    chk(pin_oe_o[15:8], 8'hFF);
    adc_enable_i = 1'b1;
    cyc(3);
    chk(pin_oe_o[15:8], 8'hC3);
    // Serial owners drive against the latch and direction
    acc(1'b1, PORT_C, REG_DIR, 8'h0F);
    acc(1'b1, PORT_C, REG_DATA, 8'h0A);
    {second_async_serial_en_i, serial_transmit_line_i} = 2'b11;
    {two_wire_serial_en_i, two_wire_data_line_out_i} = 2'b11;
    {two_wire_data_line_oe_i, two_wire_clock_line_oe_i} = 2'b11;
    cyc(3);
    chk(pin_oe_o[19:16], 4'hD);
    chk(pin_out_o[19:16] & 4'hD, 4'h5);
    two_wire_data_line_oe_i = 1'b0;
    cyc(4);
    chk(pin_oe_o[18], 1'b0);
    chk(pin_level_o[18], 1'b1);
    {second_async_serial_en_i, two_wire_serial_en_i} = 2'b00;
    cyc(3);
    chk(pin_oe_o[23:16], 8'h0F);
    chk(pin_out_o[19:16], 4'hA);
    {bkgd_oe_i, bkgd_out_i} = 2'b10;
    acc(1'b1, PORT_G, REG_DATA, 8'h01);
    chk(pin_oe_o[48], 1'b1);
    chk(pin_out_o[48], 1'b0);
    sysopt_wr_i = 1'b1;
    cyc(1);
    sysopt_wr_i = 1'b0;
    cyc(3);
    chk(background_pin_enable_o, 1'b0);
    chk({pin_oe_o[48], pin_out_o[48]}, 2'b11);
    acc(1'b0, PORT_G, REG_DATA, 8'h00);
    chk(cpu_rdata_o, 8'h05);
    // Background takes the pin back when its enable is set again
    {sysopt_wr_i, sysopt_bkgd_pe_i} = 2'b11;
    cyc(1);
    sysopt_wr_i = 1'b0;
    cyc(3);
    chk({background_pin_enable_o, pin_pullup_o[48]}, 2'b11);
    chk({pin_oe_o[48], pin_out_o[48]}, 2'b10);
    print_verdict();
  end
endmodule
